//--- sac_regs.svh
`ifndef SAC_REGS_SVH
`define SAC_REGS_SVH

// ----------------------------------------------------------------------------
// register offsets (byte-wide registers on the plain register port)
// ----------------------------------------------------------------------------
`define SAC_OFS_SC1 4'h0
`define SAC_OFS_SC2 4'h1
`define SAC_OFS_RH 4'h2
`define SAC_OFS_RL 4'h3
`define SAC_OFS_CVH 4'h4
`define SAC_OFS_CVL 4'h5
`define SAC_OFS_CFG 4'h6
`define SAC_OFS_PC1 4'h7
`define SAC_OFS_PC2 4'h8
`define SAC_OFS_PC3 4'h9

// ----------------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------------
`define SAC_SC1_COCO 7
`define SAC_SC1_AIEN 6
`define SAC_SC1_CONT 5
`define SAC_SC2_ACT 7
`define SAC_SC2_TRG 6
`define SAC_SC2_ACFE 5
`define SAC_SC2_ACFGT 4
`define SAC_CFG_LPC 7
`define SAC_CFG_LSMP 4

// ----------------------------------------------------------------------------
// channel codes and reset values
// ----------------------------------------------------------------------------
`define SAC_CH_EXT_LAST 5'h17
`define SAC_CH_TEMP 5'h1a
`define SAC_CH_BANDGAP 5'h1b
`define SAC_CH_OFF 5'h1f
`define SAC_SC1_RST 8'h1f

// ----------------------------------------------------------------------------
// timing counts (in conversion clock ticks, settle in bus clocks)
// ----------------------------------------------------------------------------
`define SAC_SMP_SHORT 5'h04
`define SAC_SMP_LONG 5'h18
// one clock for the registered trial code, four for the comparator synchroniser
`define SAC_SETTLE 3'h5

`endif

//--- sac_pkg.sv
package sac_pkg;

  // conversion clock sources
  typedef enum logic [1:0] {
    sac_src_bus,
    sac_src_bus_half,
    sac_src_alt,
    sac_src_local
  } sac_clk_src_e;

  // result formats
  typedef enum logic [1:0] {
    sac_mode_8,
    sac_mode_12,
    sac_mode_10,
    sac_mode_rsv
  } sac_mode_e;

  // converter sequencer
  typedef enum logic [1:0] {
    sac_idle,
    sac_sample,
    sac_trial,
    sac_done
  } sac_state_e;

  // register port request
  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } sac_bus_s;

  // power state of the surrounding chip
  typedef struct packed {
    logic wait_mode;
    logic stop3_mode;
    logic stop2_mode;
  } sac_power_s;

  // controls toward the analog front end
  typedef struct packed {
    logic [4:0] mux_sel;
    logic ext_en;
    logic temp_en;
    logic bandgap_en;
    logic sample;
    logic [11:0] dac_code;
    logic sar_power;
    logic high_power;
  } sac_analog_s;

endpackage

//--- sac_control.sv
// Notes on behaviour
// RL1 - code 11010 routes temperature sensor to sampler
// RL2 - code 11011 routes bandgap reference to sampler
// RL3 - reserved channel codes give undefined results
// RL4 - bits of absent channels are reserved
// RL5 - four conversion clock sources selectable
// RL6 - alternate source is external reference clock
// RL7 - divide field scales source into conversion clock
// RL8 - alternate clock keeps running in wait
// RL9 - alternate clock unusable in stop states
// RL10 - counter overflow starts conversion when enabled
// RL11 - hardware trigger works in run, wait, stop3
// RL12 - successive approximation yields twelve bit result
// RL13 - right-justified 12, 10 or 8 bit results
// RL14 - single or continuous; single returns to idle
// RL15 - optional compare, less-than or greater-equal
// RL16 - completion flag with interrupt request
// RL17 - sample time and power trade configurable
// RL18 - keeps converting in wait and stop3
// RL19 - software uses long sample, slow clock for sensor
// RL20 - multiplexer covers up to 28 channels
// RL21 - codes 0 to 23 select external inputs
// RL22 - all-ones code powers off and isolates input
// RL23 - control write aborts and restarts conversion
//
// Decided for this implementation: the plain strobed port and the register addresses.
`timescale 1ns/10ps
`default_nettype none
`include "sac_regs.svh"

module sac_control
  import sac_pkg::*;
#(
  parameter logic [23:0] CHAN_PRESENT = 24'hffffff
) (
  // clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // register port
  input wire sac_bus_s bus_in,
  output logic [7:0] rdata,
  // chip power state
  input wire sac_power_s power_in,
  // asynchronous inputs
  input wire logic hw_conv_trigger,
  input wire logic ext_reference_clock,
  input wire logic local_async_conv_clock,
  input wire logic cmp_hi,
  // analog front end and pins
  output sac_analog_s analog_out,
  output logic [23:0] pin_ctrl,
  // interrupt request
  output logic conv_irq
);

  // ----------------------------------------------------------------------------
  // input synchronisers
  // ----------------------------------------------------------------------------
  logic [3:0] raw_in; // async inputs in one vector
  logic [3:0] sync1_reg; // first stage, read only by the second
  logic [3:0] sync2_reg; // second stage
  logic [3:0] sync3_reg; // third stage
  logic [3:0] stable_reg; // accepted value once stages two and three agree
  logic [3:0] stable_prev_reg; // for edge detection
  logic [3:0] agree;

  assign raw_in = {cmp_hi, hw_conv_trigger, local_async_conv_clock, ext_reference_clock};
  assign agree = ~(sync2_reg ^ sync3_reg);

  // three flops, then a change is taken only when two and three agree
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      sync1_reg <= 4'h0;
      sync2_reg <= 4'h0;
      sync3_reg <= 4'h0;
      stable_reg <= 4'h0;
      stable_prev_reg <= 4'h0;
    end else begin
      sync1_reg <= raw_in;
      sync2_reg <= sync1_reg;
      sync3_reg <= sync2_reg;
      stable_reg <= (agree & sync3_reg) | (~agree & stable_reg);
      stable_prev_reg <= stable_reg;
    end
  end

  logic alt_rise; // rising edge of the external reference clock
  logic local_rise; // rising edge of the local asynchronous clock
  logic hw_rise; // counter overflow event
  logic cmp_level; // comparator: input at or above trial code

  assign alt_rise = stable_reg[0] & ~stable_prev_reg[0]; // RL6
  assign local_rise = stable_reg[1] & ~stable_prev_reg[1];
  assign hw_rise = stable_reg[2] & ~stable_prev_reg[2];
  assign cmp_level = stable_reg[3];

  // ----------------------------------------------------------------------------
  // register port decode
  // ----------------------------------------------------------------------------
  logic wr_sc1;
  logic rd_rl;
  logic [4:0] ch_reg; // channel_select_field
  logic aien_reg; // completion interrupt enable
  logic cont_reg; // continuous conversion
  logic coco_reg; // conversion complete flag
  logic trg_reg; // hardware trigger select
  logic acfe_reg; // compare enable
  logic acfgt_reg; // compare greater-or-equal
  logic [11:0] cv_reg; // compare value
  logic lpc_reg; // low power, slower conversion
  logic [1:0] div_reg; // clock_divide_field
  logic lsmp_reg; // long sample
  sac_mode_e mode_reg; // result format
  sac_clk_src_e src_reg; // conversion clock source
  logic [23:0] pc_reg; // pin control, digital buffers off
  logic [11:0] result_reg; // last accepted result

  assign wr_sc1 = bus_in.wr && (bus_in.addr == `SAC_OFS_SC1);
  assign rd_rl = bus_in.rd && (bus_in.addr == `SAC_OFS_RL);

  // control registers written by software
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ch_reg <= `SAC_CH_OFF;
      aien_reg <= 1'b0;
      cont_reg <= 1'b0;
      trg_reg <= 1'b0;
      acfe_reg <= 1'b0;
      acfgt_reg <= 1'b0;
      cv_reg <= 12'h000;
      lpc_reg <= 1'b0;
      div_reg <= 2'h0;
      lsmp_reg <= 1'b0;
      mode_reg <= sac_mode_8;
      src_reg <= sac_src_bus;
      pc_reg <= 24'h000000;
    end else if (bus_in.wr) begin
      case (bus_in.addr)
        `SAC_OFS_SC1: begin
          ch_reg <= bus_in.wdata[4:0];
          aien_reg <= bus_in.wdata[`SAC_SC1_AIEN];
          cont_reg <= bus_in.wdata[`SAC_SC1_CONT];
        end
        `SAC_OFS_SC2: begin
          trg_reg <= bus_in.wdata[`SAC_SC2_TRG];
          acfe_reg <= bus_in.wdata[`SAC_SC2_ACFE];
          acfgt_reg <= bus_in.wdata[`SAC_SC2_ACFGT];
        end
        `SAC_OFS_CVH: cv_reg[11:8] <= bus_in.wdata[3:0];
        `SAC_OFS_CVL: cv_reg[7:0] <= bus_in.wdata;
        `SAC_OFS_CFG: begin
          lpc_reg <= bus_in.wdata[`SAC_CFG_LPC]; // RL17
          div_reg <= bus_in.wdata[6:5];
          lsmp_reg <= bus_in.wdata[`SAC_CFG_LSMP]; // RL17
          mode_reg <= sac_mode_e'(bus_in.wdata[3:2]);
          src_reg <= sac_clk_src_e'(bus_in.wdata[1:0]);
        end
        // bits of absent channels never store and read as zero
        `SAC_OFS_PC1: pc_reg[7:0] <= bus_in.wdata & CHAN_PRESENT[7:0]; // RL4
        `SAC_OFS_PC2: pc_reg[15:8] <= bus_in.wdata & CHAN_PRESENT[15:8]; // RL4
        `SAC_OFS_PC3: pc_reg[23:16] <= bus_in.wdata & CHAN_PRESENT[23:16]; // RL4
        default: begin
          // unmapped offsets ignore writes
        end
      endcase
    end
  end

  // ----------------------------------------------------------------------------
  // conversion clock: source select and divider
  // ----------------------------------------------------------------------------
  logic half_reg; // bus clock halved
  logic src_tick; // one pulse per selected source period
  logic [2:0] div_cnt_reg;
  logic [2:0] div_limit;
  logic conv_tick_reg; // one pulse per conversion clock period

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      half_reg <= 1'b0;
    end else begin
      half_reg <= ~half_reg;
    end
  end

  // bus clocks halt in stop3; the alternate clock is barred in both stops
  always_comb begin
    src_tick = 1'b0;
    case (src_reg) // RL5
      sac_src_bus: src_tick = !power_in.stop3_mode;
      sac_src_bus_half: src_tick = half_reg && !power_in.stop3_mode;
      // wait mode leaves the alternate clock running
      sac_src_alt: src_tick = alt_rise && !power_in.stop3_mode && !power_in.stop2_mode; // RL8 RL9
      sac_src_local: src_tick = local_rise; // RL18
      default: src_tick = 1'b0;
    endcase
    if (power_in.stop2_mode) begin
      src_tick = 1'b0;
    end
  end

  // divide by 1, 2, 4 or 8; software keeps the result in range
  assign div_limit = 3'((4'h1 << div_reg) - 4'h1); // RL7

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      div_cnt_reg <= 3'h0;
      conv_tick_reg <= 1'b0;
    end else begin
      conv_tick_reg <= 1'b0;
      if (src_tick) begin
        if (div_cnt_reg >= div_limit) begin // RL7
          div_cnt_reg <= 3'h0;
          conv_tick_reg <= 1'b1;
        end else begin
          div_cnt_reg <= div_cnt_reg + 3'h1;
        end
      end
    end
  end

  // ----------------------------------------------------------------------------
  // conversion sequencer
  // ----------------------------------------------------------------------------
  sac_state_e state_reg;
  logic [4:0] smp_cnt_reg; // sample ticks so far
  logic [4:0] smp_limit;
  logic [3:0] bit_reg; // bit under trial
  logic [11:0] sar_reg; // approximation register
  logic [2:0] settle_reg; // bus clocks left for comparator to settle
  logic lp_half_reg; // low power: first of two ticks per bit seen
  logic sw_start;
  logic hw_start;
  logic abort;

  assign smp_limit = lsmp_reg ? `SAC_SMP_LONG : `SAC_SMP_SHORT; // RL17
  // all-ones channel code never starts anything, nor does a write in stop2
  assign sw_start = wr_sc1 && !trg_reg && (bus_in.wdata[4:0] != `SAC_CH_OFF)
                    && !power_in.stop2_mode; // RL23 RL22
  // overflow starts from idle; stop2 removes the module entirely
  assign hw_start = trg_reg && hw_rise && (ch_reg != `SAC_CH_OFF)
                    && !power_in.stop2_mode; // RL10 RL11
  assign abort = wr_sc1 || power_in.stop2_mode; // RL23

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state_reg <= sac_idle;
      smp_cnt_reg <= 5'h00;
      bit_reg <= 4'h0;
      sar_reg <= 12'h000;
      settle_reg <= 3'h0;
      lp_half_reg <= 1'b0;
    end else if (abort) begin
      // a control write cancels the current one, then maybe restarts
      state_reg <= sw_start ? sac_sample : sac_idle; // RL23
      smp_cnt_reg <= 5'h00;
    end else begin
      case (state_reg)
        sac_idle: begin
          if (hw_start) begin
            state_reg <= sac_sample; // RL10
            smp_cnt_reg <= 5'h00;
          end
        end
        sac_sample: begin
          if (conv_tick_reg) begin
            if (smp_cnt_reg >= smp_limit - 5'h01) begin
              state_reg <= sac_trial;
              sar_reg <= 12'h800; // RL12
              bit_reg <= 4'hb;
              settle_reg <= `SAC_SETTLE;
              lp_half_reg <= 1'b0;
            end else begin
              smp_cnt_reg <= smp_cnt_reg + 5'h01;
            end
          end
        end
        sac_trial: begin
          // the synchroniser delays the comparator, so wait it out
          if (settle_reg != 3'h0) begin
            settle_reg <= settle_reg - 3'h1;
          end else if (conv_tick_reg && lpc_reg && !lp_half_reg) begin
            lp_half_reg <= 1'b1; // RL17
          end else if (conv_tick_reg) begin
            lp_half_reg <= 1'b0;
            // keep the trial bit only if the input reaches it
            sar_reg[bit_reg] <= cmp_level; // RL12
            if (bit_reg == 4'h0) begin
              state_reg <= sac_done;
            end else begin
              bit_reg <= bit_reg - 4'h1;
              sar_reg[bit_reg - 4'h1] <= 1'b1;
              settle_reg <= `SAC_SETTLE;
            end
          end
        end
        sac_done: begin
          if (cont_reg && ch_reg != `SAC_CH_OFF) begin
            state_reg <= sac_sample; // RL14
            smp_cnt_reg <= 5'h00;
          end else begin
            state_reg <= sac_idle; // RL14
          end
        end
        default: state_reg <= sac_idle;
      endcase
    end
  end

  // ----------------------------------------------------------------------------
  // result formatting and compare
  // ----------------------------------------------------------------------------
  logic [11:0] fmt_sar; // sar value, right-justified in chosen width
  logic [11:0] fmt_cv; // compare value at the same width
  logic cmp_true;
  logic done_ok;

  always_comb begin
    fmt_sar = sar_reg;
    fmt_cv = cv_reg;
    case (mode_reg) // RL13
      sac_mode_8: begin
        fmt_sar = {4'h0, sar_reg[11:4]};
        fmt_cv = {4'h0, cv_reg[7:0]};
      end
      sac_mode_10: begin
        fmt_sar = {2'h0, sar_reg[11:2]};
        fmt_cv = {2'h0, cv_reg[9:0]};
      end
      sac_mode_12: begin
        fmt_sar = sar_reg;
        fmt_cv = cv_reg;
      end
      default: begin
        fmt_sar = sar_reg;
        fmt_cv = cv_reg;
      end
    endcase
  end

  assign cmp_true = acfgt_reg ? (fmt_sar >= fmt_cv) : (fmt_sar < fmt_cv); // RL15
  assign done_ok = (state_reg == sac_done) && (!acfe_reg || cmp_true); // RL15

  // result held until the next accepted conversion
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      result_reg <= 12'h000;
    end else if (done_ok) begin
      result_reg <= fmt_sar; // RL13
    end
  end

  // completion flag: a new completion beats a clearing write or read
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      coco_reg <= 1'b0;
    end else if (done_ok) begin
      coco_reg <= 1'b1; // RL16
    end else if (wr_sc1 || rd_rl) begin
      coco_reg <= 1'b0;
    end
  end

  // interrupt follows the flag one cycle later
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      conv_irq <= 1'b0;
    end else begin
      conv_irq <= coco_reg && aien_reg; // RL16
    end
  end

  // ----------------------------------------------------------------------------
  // analog front end controls
  // ----------------------------------------------------------------------------
  // reserved codes enable no source, so their result is whatever floats
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      // mux code matches the channel register reset, so routes stay coherent
      analog_out <= '0;
      analog_out.mux_sel <= `SAC_CH_OFF;
    end else begin
      analog_out.mux_sel <= ch_reg; // RL20 RL3
      analog_out.ext_en <= (ch_reg <= `SAC_CH_EXT_LAST); // RL21
      analog_out.temp_en <= (ch_reg == `SAC_CH_TEMP); // RL1
      analog_out.bandgap_en <= (ch_reg == `SAC_CH_BANDGAP); // RL2
      analog_out.sample <= (state_reg == sac_sample);
      analog_out.dac_code <= sar_reg;
      // all-ones code keeps the converter unpowered
      analog_out.sar_power <= (state_reg != sac_idle) && (ch_reg != `SAC_CH_OFF); // RL22
      analog_out.high_power <= !lpc_reg; // RL17
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      pin_ctrl <= 24'h000000;
    end else begin
      pin_ctrl <= pc_reg;
    end
  end

  // ----------------------------------------------------------------------------
  // read data, valid the cycle after the strobe
  // ----------------------------------------------------------------------------
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rdata <= 8'h00;
    end else if (bus_in.rd) begin
      case (bus_in.addr)
        `SAC_OFS_SC1: rdata <= {coco_reg, aien_reg, cont_reg, ch_reg};
        `SAC_OFS_SC2: rdata <= {state_reg != sac_idle, trg_reg, acfe_reg, acfgt_reg, 4'h0};
        `SAC_OFS_RH: rdata <= {4'h0, result_reg[11:8]};
        `SAC_OFS_RL: rdata <= result_reg[7:0];
        `SAC_OFS_CVH: rdata <= {4'h0, cv_reg[11:8]};
        `SAC_OFS_CVL: rdata <= cv_reg[7:0];
        `SAC_OFS_CFG: rdata <= {lpc_reg, div_reg, lsmp_reg, mode_reg, src_reg};
        `SAC_OFS_PC1: rdata <= pc_reg[7:0];
        `SAC_OFS_PC2: rdata <= pc_reg[15:8];
        `SAC_OFS_PC3: rdata <= pc_reg[23:16];
        default: rdata <= 8'h00;
      endcase
    end else begin
      rdata <= 8'h00;
    end
  end

endmodule
`default_nettype wire

//--- sac_control_sva.sv
`timescale 1ns/10ps
`default_nettype none
// ------------------------------------------
// port checks for the converter control
// ------------------------------------------
module sac_control_sva
  import sac_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // register port and chip state
  input wire sac_bus_s bus_in,
  input wire sac_power_s power_in,
  input wire logic hw_conv_trigger,
  // analog side
  input wire sac_analog_s analog_out
);
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);
  // shadows of trigger mode and low-power bit, since the ports hide them
  logic hw_sh;
  logic lpc_sh;
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      hw_sh <= 1'b0;
      lpc_sh <= 1'b0;
    end else if (bus_in.wr && bus_in.addr == 4'h1) begin
      hw_sh <= bus_in.wdata[6];
    end else if (bus_in.wr && bus_in.addr == 4'h6) begin
      lpc_sh <= bus_in.wdata[7];
    end
  end
  temp_route_a: assert property (analog_out.temp_en == (analog_out.mux_sel == 5'h1a))
    else $error("temperature route wrong");
  bandgap_route_a: assert property (analog_out.bandgap_en == (analog_out.mux_sel == 5'h1b))
    else $error("bandgap route wrong");
  ext_route_a: assert property (analog_out.ext_en == (analog_out.mux_sel <= 5'h17))
    else $error("external route wrong");
  off_power_a: assert property (analog_out.mux_sel == 5'h1f |-> !analog_out.sar_power)
    else $error("converter powered while off");
  power_mode_a: assert property ($stable(lpc_sh) [*3] |-> analog_out.high_power == !lpc_sh)
    else $error("power mode wrong");
  sw_start_a: assert property (bus_in.wr && bus_in.addr == 4'h0 && bus_in.wdata[4:0] != 5'h1f
    && !hw_sh && power_in == '0 |-> ##[1:3] analog_out.sample)
    else $error("write did not start sampling");
  hw_start_a: assert property ($rose(hw_conv_trigger) && hw_sh && !analog_out.sar_power
    && analog_out.mux_sel != 5'h1f && power_in == '0 |-> ##[2:8] analog_out.sample)
    else $error("trigger did not start sampling");
  stop2_block_a: assert property (power_in.stop2_mode [*3] |-> !analog_out.sar_power)
    else $error("converter busy in stop2");
  // main scenarios
  cover property ($fell(analog_out.sar_power));
  cover property (power_in.stop3_mode && analog_out.sample);
  cover property ($rose(hw_conv_trigger) && hw_sh);
endmodule

bind sac_control sac_control_sva u_sva (
  .clk(clk), .arst_n(arst_n), .bus_in(bus_in), .power_in(power_in),
  .hw_conv_trigger(hw_conv_trigger), .analog_out(analog_out)
);
`default_nettype wire

//--- sac_analog_model.sv
`timescale 1ns/10ps
`default_nettype none
// ------------------------------------------
// analog inputs: fixed level per source, ideal comparator
// ------------------------------------------
module sac_analog_model
  import sac_pkg::*;
(
  // clock
  input wire logic clk,
  // front end controls
  input wire sac_analog_s analog_out,
  output logic cmp_hi
);
  logic [11:0] level; // level of the routed source
  logic live; // a source reaches the sampler
  logic junk_reg = 1'b0; // floating input, so no stale value looks valid
  // source selection follows the enables only
  always_comb begin
    live = 1'b1;
    level = 12'h000;
    if (analog_out.ext_en) begin
      level = 12'h123 + 12'h07f * analog_out.mux_sel;
    end else if (analog_out.temp_en) begin
      level = 12'h5c3;
    end else if (analog_out.bandgap_en) begin
      level = 12'h3e8;
    end else begin
      live = 1'b0;
    end
  end
  always_ff @(posedge clk) junk_reg <= ~junk_reg;
  assign cmp_hi = live ? (level >= analog_out.dac_code) : junk_reg;
endmodule
`default_nettype wire

//--- sac_control_bench.sv
`timescale 1ns/10ps
`default_nettype none
// ------------------------------------------
// self-checking bench for the converter control
// ------------------------------------------
module sac_control_bench;
  import sac_pkg::*;
  typedef struct packed {
    logic [4:0] ch;
    logic [7:0] cfg;
    logic [2:0] pw;
  } sac_row_s;
  // stimulus and observed outputs
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic ext_reference_clock = 1'b0;
  logic local_async_conv_clock = 1'b0;
  logic hw_conv_trigger = 1'b0;
  sac_bus_s bus_in = '0;
  sac_power_s power_in = '0;
  logic [7:0] rdata;
  sac_analog_s analog_out;
  logic [23:0] pin_ctrl;
  logic conv_irq;
  logic cmp_hi;
  int bad_count = 0;
  int checks_done = 0;
  // ordinary conversions: channel, config byte, power state
  sac_row_s rows [9] = '{
    '{5'h00, 8'h04, 3'b000},
    '{5'h17, 8'h84, 3'b000},
    '{5'h05, 8'h00, 3'b000},
    '{5'h09, 8'h08, 3'b000},
    '{5'h11, 8'h2d, 3'b000},
    '{5'h1a, 8'h75, 3'b000},
    '{5'h1b, 8'h06, 3'b100},
    '{5'h10, 8'h46, 3'b000},
    '{5'h0c, 8'h17, 3'b010}
  };
  always #50 clk = ~clk;
  // source clocks unrelated in phase to the bus clock
  always #53 ext_reference_clock = ~ext_reference_clock;
  always #37 local_async_conv_clock = ~local_async_conv_clock;
  // top four channels left out, so their pin bits must stay reserved
  sac_control #(.CHAN_PRESENT(24'h0fffff)) u_dut (
    .clk(clk), .arst_n(arst_n), .bus_in(bus_in), .rdata(rdata), .power_in(power_in),
    .hw_conv_trigger(hw_conv_trigger), .ext_reference_clock(ext_reference_clock),
    .local_async_conv_clock(local_async_conv_clock), .cmp_hi(cmp_hi),
    .analog_out(analog_out), .pin_ctrl(pin_ctrl), .conv_irq(conv_irq)
  );
  sac_analog_model u_ana (.clk(clk), .analog_out(analog_out), .cmp_hi(cmp_hi));
  task automatic wrap_up();
    if (bad_count == 0 && checks_done > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic chk_val(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic chk_bit(input logic got, input logic exp);
    chk_val({15'h0, got}, {15'h0, exp});
  endtask
  // one-cycle strobes, launched right after an edge
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    bus_in <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    bus_in.wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge clk);
    bus_in <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clk);
    bus_in.rd <= 1'b0;
    #1 d = rdata;
  endtask
  // poll one register bit, bounded so a hang ends the run
  task automatic wait_flag(input logic [3:0] a, input int b, input logic v);
    logic [7:0] d;
    int n;
    n = 0;
    rd(a, d);
    while (d[b] !== v) begin
      n++;
      if (n > 3000) begin
        bad_count++;
        wrap_up();
      end
      rd(a, d);
    end
  endtask
  // expected level of a channel in the chosen format
  function automatic logic [11:0] expect_of(input logic [4:0] ch, input logic [1:0] m);
    logic [11:0] l;
    l = (ch == 5'h1a) ? 12'h5c3 : (ch == 5'h1b) ? 12'h3e8 : 12'h123 + 12'h07f * ch;
    if (m == 2'b00) return l >> 4;
    if (m == 2'b10) return l >> 2;
    return l;
  endfunction
  // wait for completion, check flag, interrupt and result
  task automatic conv(input logic [4:0] ch, input logic [7:0] cfg);
    logic [7:0] h;
    logic [7:0] l;
    wait_flag(4'h0, 7, 1'b1);
    @(posedge clk);
    #1 chk_bit(conv_irq, 1'b1);
    rd(4'h2, h);
    rd(4'h3, l);
    chk_val({h, l}, {4'h0, expect_of(ch, cfg[3:2])});
    rd(4'h0, h);
    chk_bit(h[7], 1'b0);
    chk_bit(conv_irq, 1'b0);
  endtask
  task automatic pulse();
    @(posedge clk);
    hw_conv_trigger <= 1'b1;
    repeat (3) @(posedge clk);
    hw_conv_trigger <= 1'b0;
  endtask
  initial begin
    logic [7:0] d;
    logic [11:0] v;
    repeat (5) @(posedge clk);
    arst_n <= 1'b1;
    rd(4'h0, d);
    chk_val(d, 8'h1f);
    rd(4'hf, d);
    chk_val(d, 8'h00);
    wr(4'h7, 8'h5a);
    rd(4'h7, d);
    chk_val({d, pin_ctrl[7:0]}, 16'h5a5a);
    wr(4'h9, 8'hff);
    rd(4'h9, d);
    chk_val(d, 8'h0f);
    foreach (rows[i]) begin
      @(posedge clk);
      power_in <= rows[i].pw;
      wr(4'h6, rows[i].cfg);
      wr(4'h0, {3'b010, rows[i].ch});
      conv(rows[i].ch, rows[i].cfg);
      rd(4'h1, d);
      chk_bit(d[7], 1'b0);
    end
    @(posedge clk);
    power_in <= '0;
    // restart in mid-sample: only the second channel counts
    wr(4'h6, 8'h04);
    wr(4'h0, 8'h43);
    wr(4'h0, 8'h41);
    conv(5'h01, 8'h04);
    // compare: greater-or-equal true, then less-than false
    v = expect_of(5'h02, 2'b01);
    wr(4'h4, {4'h0, v[11:8]});
    wr(4'h5, v[7:0]);
    wr(4'h1, 8'h30);
    wr(4'h0, 8'h42);
    conv(5'h02, 8'h04);
    wr(4'h1, 8'h20);
    wr(4'h0, 8'h42);
    wait_flag(4'h1, 7, 1'b0);
    rd(4'h0, d);
    chk_bit(d[7], 1'b0);
    // continuous, then stopped by the all-ones code
    wr(4'h1, 8'h00);
    wr(4'h0, 8'h64);
    conv(5'h04, 8'h04);
    conv(5'h04, 8'h04);
    wr(4'h0, 8'h1f);
    wait_flag(4'h1, 7, 1'b0);
    // hardware trigger: the write alone must not start
    wr(4'h1, 8'h40);
    wr(4'h0, 8'h47);
    rd(4'h1, d);
    chk_bit(d[7], 1'b0);
    pulse();
    conv(5'h07, 8'h04);
    @(posedge clk);
    power_in <= 3'b010;
    wr(4'h6, 8'h07);
    pulse();
    conv(5'h07, 8'h07);
    // stop2 in mid-conversion aborts it
    @(posedge clk);
    power_in <= '0;
    wr(4'h1, 8'h00);
    wr(4'h6, 8'h04);
    wr(4'h0, 8'h08);
    @(posedge clk);
    power_in <= 3'b001;
    repeat (4) @(posedge clk);
    power_in <= '0;
    rd(4'h1, d);
    chk_bit(d[7], 1'b0);
    // alternate source frozen in stop3, then finishes once running
    @(posedge clk);
    power_in <= 3'b010;
    wr(4'h6, 8'h06);
    wr(4'h0, 8'h45);
    repeat (600) @(posedge clk);
    rd(4'h0, d);
    chk_bit(d[7], 1'b0);
    rd(4'h1, d);
    chk_bit(d[7], 1'b1);
    @(posedge clk);
    power_in <= '0;
    conv(5'h05, 8'h06);
    wrap_up();
  end
endmodule
`default_nettype wire
